// ==== seq_defines.svh ====
// constants for the step sequencer: offsets, fields, reset values, timing
`ifndef SEQ_DEFINES_SVH
`define SEQ_DEFINES_SVH
// register byte offsets on the wishbone slave
`define SEQ_OFS_MODE 8'h00
`define SEQ_OFS_RETAIN 8'h04
`define SEQ_OFS_CTRL 8'h08
`define SEQ_OFS_STATUS 8'h0c
`define SEQ_OFS_OUT 8'h10
// window tags in adr[7:6]: step values and step durations, one word each
`define SEQ_WIN_STEP 2'h1
`define SEQ_WIN_DUR 2'h2
// control fields
`define SEQ_CTRL_VOLT 0
`define SEQ_CTRL_HOUR 1
// reset values
`define SEQ_MODE_RST 16'h0000
`define SEQ_RETAIN_RST 16'h0000
`define SEQ_CTRL_RST 2'h0
// step value full scale, 0.1 percent units
`define SEQ_PCT_FULL 1000
// timing: clock period and one tenth of a second, both in ns
`define SEQ_CLK_NS 8
`define SEQ_TENTH_SEC_NS 100000000
`define SEQ_TENTH_CYCLES (`SEQ_TENTH_SEC_NS / `SEQ_CLK_NS)
// tenths of a second in one tenth of an hour
`define SEQ_TENTHS_PER_TENTH_HOUR 3600
`endif

// ==== seq_pkg.sv ====
// types shared by the step sequencer files
package seq_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RUN = 3'b001,
        ST_HOLD = 3'b010,
        ST_DONE = 3'b011,
        ST_OFF = 3'b100
    } seq_state_t;
    typedef enum logic [1:0] {
        MODE_STOP = 2'b00,
        MODE_HOLD = 2'b01,
        MODE_LOOP = 2'b10
    } run_mode_t;
endpackage

// ==== step_timer.sv ====
// elapsed-time counter for one step, in tenths of a second or of an hour
`timescale 1ns/1ps
`include "seq_defines.svh"
module step_timer #(
    parameter int TENTH_CYCLES = `SEQ_TENTH_CYCLES,
    parameter int HOUR_FACTOR = `SEQ_TENTHS_PER_TENTH_HOUR
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic clear_i,
    input wire logic load_i,
    input wire logic [15:0] load_val_i,
    input wire logic unit_hour_i,
    input wire logic [15:0] duration_i,
    output logic [15:0] elapsed_o,
    output logic done_o
);
    logic [31:0] pre_r;
    logic [11:0] hr_r;
    logic [15:0] elapsed_r;
    wire pre_wrap = (pre_r == 32'(TENTH_CYCLES - 1));
    wire hr_wrap = (hr_r == 12'(HOUR_FACTOR - 1));
    wire tick = en_i && pre_wrap && (!unit_hour_i || hr_wrap);

    // prescaler restarts on clear or load, so a resumed step loses under one tenth
    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i || load_i) begin
            pre_r <= 32'h0;
            hr_r <= 12'h0;
        end else if (en_i) begin
            pre_r <= pre_wrap ? 32'h0 : pre_r + 32'h1;
            if (pre_wrap) begin
                hr_r <= (hr_wrap || !unit_hour_i) ? 12'h0 : hr_r + 12'h1;
            end
        end
    end

    // elapsed count saturates at the top of the duration range
    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            elapsed_r <= 16'h0;
        end else if (load_i) begin
            elapsed_r <= load_val_i;
        end else if (tick && elapsed_r != 16'hffff) begin
            elapsed_r <= elapsed_r + 16'h1;
        end
    end

    assign elapsed_o = elapsed_r;
    assign done_o = (elapsed_r >= duration_i);

    clear_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        clear_i |=> elapsed_r == 16'h0)
        else $error("step time not cleared");
endmodule

// ==== step_sequencer_run_control.sv ====
// step sequencer: sixteen signed steps driving frequency or voltage setpoint
//
// Chosen here: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`include "seq_defines.svh"
module step_sequencer_run_control #(
    parameter int NUM_STEPS = 16,
    parameter int TENTH_CYCLES = `SEQ_TENTH_CYCLES,
    parameter int HOUR_FACTOR = `SEQ_TENTHS_PER_TENTH_HOUR
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic run_cmd_i,
    input wire logic stop_cmd_i,
    input wire logic power_fail_i,
    input wire logic [15:0] max_freq_i,
    input wire logic [15:0] rated_volt_i,
    output logic [15:0] freq_ref_o,
    output logic [15:0] volt_ref_o,
    output logic reverse_o,
    output logic running_o,
    output logic [3:0] step_o
);
    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // byte-lane merge of the low half word
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] sel);
        merge16 = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
    endfunction

    // decimal digit of the retention word: digit 0 units, 1 tens
    function automatic logic digit_on(input logic [15:0] v, input logic tens);
        logic [15:0] d;
        d = tens ? (v / 16'd10) : v;
        digit_on = ((d % 16'd10) == 16'd1);
    endfunction

    // magnitude of a clamped percentage times full scale
    function automatic logic [15:0] scale(input logic signed [15:0] pct,
                                          input logic [15:0] full);
        logic [15:0] mag;
        logic [31:0] prod;
        mag = pct[15] ? 16'(-pct) : 16'(pct);
        if (mag > 16'(`SEQ_PCT_FULL)) begin
            mag = 16'(`SEQ_PCT_FULL);
        end
        prod = mag * full;
        scale = 16'(prod / 32'(`SEQ_PCT_FULL));
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // registers

    localparam logic [3:0] LAST = 4'(NUM_STEPS - 1);
    logic [15:0] mode_r;
    logic [15:0] retain_r;
    logic [1:0] ctrl_r;
    logic signed [15:0] step_val_r [NUM_STEPS];
    logic [15:0] dur_r [NUM_STEPS];
    logic ack_r;
    logic [31:0] rdata_r;
    seq_pkg::seq_state_t state_r, state_nxt;
    logic [3:0] step_r, step_nxt;
    logic [3:0] sav_step_r;
    logic [15:0] sav_el_r;
    logic sav_hold_r;
    logic pwr_res_r, stop_res_r;
    logic [15:0] elapsed;
    logic tmr_done;

    // bus decode
    wire req = wb_cyc_i && wb_stb_i;
    wire wr_now = req && wb_we_i && ack_r;
    wire [1:0] win = wb_adr_i[7:6];
    wire [3:0] idx = wb_adr_i[5:2];
    wire is_step = (win == `SEQ_WIN_STEP);
    wire is_dur = (win == `SEQ_WIN_DUR);
    wire ctl_volt = ctrl_r[`SEQ_CTRL_VOLT];
    wire ctl_hour = ctrl_r[`SEQ_CTRL_HOUR];
    wire ret_pwr = digit_on(retain_r, 1'b0);
    wire ret_stop = digit_on(retain_r, 1'b1);
    wire [1:0] mode = mode_r[1:0];

    // read mux; unmapped offsets read zero and still get an ack
    wire [31:0] status = {8'h0, elapsed, 1'b0, state_r, step_r};
    wire [31:0] rd_word =
        is_step ? {16'h0, step_val_r[idx]} :
        is_dur ? {16'h0, dur_r[idx]} :
        (wb_adr_i == `SEQ_OFS_MODE) ? {16'h0, mode_r} :
        (wb_adr_i == `SEQ_OFS_RETAIN) ? {16'h0, retain_r} :
        (wb_adr_i == `SEQ_OFS_CTRL) ? {30'h0, ctrl_r} :
        (wb_adr_i == `SEQ_OFS_STATUS) ? status :
        (wb_adr_i == `SEQ_OFS_OUT) ? {volt_ref_o, freq_ref_o} : 32'h0;

    // one wait state: ack a cycle after the request, drop it the next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0;
        end else begin
            ack_r <= req && !ack_r;
            rdata_r <= rd_word;
        end
    end
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdata_r;

    // writes land on the edge where the master sees ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_r <= `SEQ_MODE_RST;
            retain_r <= `SEQ_RETAIN_RST;
            ctrl_r <= `SEQ_CTRL_RST;
        end else if (wr_now) begin
            if (wb_adr_i == `SEQ_OFS_MODE) mode_r <= merge16(mode_r, wb_dat_i, wb_sel_i);
            if (wb_adr_i == `SEQ_OFS_RETAIN) retain_r <= merge16(retain_r, wb_dat_i, wb_sel_i);
            if (wb_adr_i == `SEQ_OFS_CTRL && wb_sel_i[0]) ctrl_r <= wb_dat_i[1:0];
        end
    end

    // step table; values outside +-100.0 percent are clamped on use
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_STEPS; i++) begin
                step_val_r[i] <= 16'sh0;
                dur_r[i] <= 16'h0;
            end
        end else if (wr_now && is_step) begin
            step_val_r[idx] <= merge16(step_val_r[idx], wb_dat_i, wb_sel_i);
        end else if (wr_now && is_dur) begin
            dur_r[idx] <= merge16(dur_r[idx], wb_dat_i, wb_sel_i);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencing

    logic tmr_clear, tmr_load, snap;
    wire in_run = (state_r == seq_pkg::ST_RUN);
    wire active = in_run || (state_r == seq_pkg::ST_HOLD);
    wire is_last = (step_r == LAST);

    // power loss outranks stop, stop outranks progress
    always_comb begin
        state_nxt = state_r;
        step_nxt = step_r;
        tmr_clear = 1'b0;
        tmr_load = 1'b0;
        snap = 1'b0;
        case (state_r)
            seq_pkg::ST_OFF: begin
                if (!power_fail_i) begin
                    if (pwr_res_r) begin
                        state_nxt = sav_hold_r ? seq_pkg::ST_HOLD : seq_pkg::ST_RUN;
                        step_nxt = sav_step_r;
                        tmr_load = 1'b1;
                    end else begin
                        state_nxt = seq_pkg::ST_IDLE;
                        step_nxt = 4'h0;
                        tmr_clear = 1'b1;
                    end
                end
            end
            seq_pkg::ST_IDLE, seq_pkg::ST_DONE: begin
                if (power_fail_i) begin
                    state_nxt = seq_pkg::ST_OFF;
                end else if (run_cmd_i) begin
                    if (state_r == seq_pkg::ST_IDLE && stop_res_r && ret_stop) begin
                        state_nxt = sav_hold_r ? seq_pkg::ST_HOLD : seq_pkg::ST_RUN;
                        step_nxt = sav_step_r;
                        tmr_load = 1'b1;
                    end else begin
                        state_nxt = seq_pkg::ST_RUN;
                        step_nxt = 4'h0;
                        tmr_clear = 1'b1;
                    end
                end
            end
            seq_pkg::ST_RUN, seq_pkg::ST_HOLD: begin
                if (power_fail_i) begin
                    state_nxt = seq_pkg::ST_OFF;
                    snap = ret_pwr;
                end else if (stop_cmd_i) begin
                    state_nxt = seq_pkg::ST_IDLE;
                    snap = ret_stop;
                end else if (in_run && tmr_done) begin
                    tmr_clear = 1'b1;
                    if (!is_last) begin
                        step_nxt = step_r + 4'h1;
                    end else if (mode == seq_pkg::MODE_HOLD) begin
                        state_nxt = seq_pkg::ST_HOLD;
                    end else if (mode == seq_pkg::MODE_LOOP) begin
                        step_nxt = 4'h0;
                    end else begin
                        state_nxt = seq_pkg::ST_DONE;
                    end
                end
            end
            default: begin
                state_nxt = seq_pkg::ST_IDLE;
                step_nxt = 4'h0;
                tmr_clear = 1'b1;
            end
        endcase
    end

    // state and position
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= seq_pkg::ST_IDLE;
            step_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            step_r <= step_nxt;
        end
    end

    // snapshot of position and time; resume flags say which event kept it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sav_step_r <= 4'h0;
            sav_el_r <= 16'h0;
            sav_hold_r <= 1'b0;
            pwr_res_r <= 1'b0;
            stop_res_r <= 1'b0;
        end else if (snap) begin
            sav_step_r <= step_r;
            sav_el_r <= elapsed;
            sav_hold_r <= (state_r == seq_pkg::ST_HOLD);
            pwr_res_r <= power_fail_i;
            stop_res_r <= !power_fail_i;
        end else if (tmr_clear || tmr_load) begin
            pwr_res_r <= 1'b0;
            stop_res_r <= 1'b0;
        end else if (power_fail_i && active) begin
            pwr_res_r <= 1'b0;
        end
    end

    step_timer #(
        .TENTH_CYCLES(TENTH_CYCLES),
        .HOUR_FACTOR(HOUR_FACTOR)
    ) u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(in_run),
        .clear_i(tmr_clear),
        .load_i(tmr_load),
        .load_val_i(sav_el_r),
        .unit_hour_i(ctl_hour),
        .duration_i(dur_r[step_r]),
        .elapsed_o(elapsed),
        .done_o(tmr_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // setpoint outputs

    wire signed [15:0] pct = active ? step_val_r[step_r] : 16'sh0;
    logic [15:0] freq_r, volt_r;
    logic rev_r;

    // only the selected setpoint is driven; the other reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            freq_r <= 16'h0;
            volt_r <= 16'h0;
            rev_r <= 1'b0;
        end else begin
            freq_r <= ctl_volt ? 16'h0 : scale(pct, max_freq_i);
            volt_r <= ctl_volt ? scale(pct, rated_volt_i) : 16'h0;
            rev_r <= !ctl_volt && pct[15];
        end
    end
    assign freq_ref_o = freq_r;
    assign volt_ref_o = volt_r;
    assign reverse_o = rev_r;
    assign running_o = active;
    assign step_o = step_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    sequence pass_end_s;
        in_run && tmr_done && is_last && !power_fail_i && !stop_cmd_i;
    endsequence

    sequence step_end_s;
        in_run && tmr_done && !is_last && !power_fail_i && !stop_cmd_i;
    endsequence

    mode_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
        pass_end_s ##0 (mode == seq_pkg::MODE_STOP) |=> !running_o ##1 freq_ref_o == 16'h0)
        else $error("pass end in stop mode did not halt");

    hold_last_a: assert property (@(posedge clk_i) disable iff (rst_i)
        pass_end_s ##0 (mode == seq_pkg::MODE_HOLD) |=> state_r == seq_pkg::ST_HOLD
        && step_r == LAST)
        else $error("pass end in hold mode did not hold last step");

    loop_again_a: assert property (@(posedge clk_i) disable iff (rst_i)
        pass_end_s ##0 (mode == seq_pkg::MODE_LOOP) |=> in_run && step_r == 4'h0)
        else $error("pass end in loop mode did not restart");

    target_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ctl_volt |=> freq_ref_o == 16'h0)
        else $error("frequency driven while voltage selected");

    reverse_dir_a: assert property (@(posedge clk_i) disable iff (rst_i)
        active && !ctl_volt |=> reverse_o == $past(pct[15]))
        else $error("direction does not follow step sign");

    pwr_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        in_run && power_fail_i && ret_pwr |=> state_r == seq_pkg::ST_OFF
        && pwr_res_r && sav_step_r == $past(step_r))
        else $error("position not kept across power loss");

    pwr_restart_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_r == seq_pkg::ST_OFF && !power_fail_i && !pwr_res_r
        |=> state_r == seq_pkg::ST_IDLE && step_r == 4'h0)
        else $error("power return without retention did not restart");

    stop_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        in_run && stop_cmd_i && !power_fail_i && ret_stop
        |=> stop_res_r && sav_step_r == $past(step_r) && !running_o)
        else $error("position not recorded at stop");

    stop_restart_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_r == seq_pkg::ST_IDLE && run_cmd_i && !power_fail_i && !(stop_res_r && ret_stop)
        |=> in_run && step_r == 4'h0)
        else $error("start after stop did not restart");

    step_adv_a: assert property (@(posedge clk_i) disable iff (rst_i)
        step_end_s |=> step_r == $past(step_r) + 4'h1 && elapsed == 16'h0)
        else $error("step did not advance in order");

    pct_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctl_volt |=> freq_ref_o <= max_freq_i || $changed(max_freq_i))
        else $error("frequency above maximum");

    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held more than one cycle");
endmodule

// ==== step_sequencer_run_control_test.sv ====
// self-checking bench for the step sequencer, driven over wishbone
`timescale 1ns/1ps
module step_sequencer_run_control_test;
    logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic [3:0] wb_sel_i, step_o, prev_step;
    logic run_cmd_i, stop_cmd_i, power_fail_i, reverse_o, running_o, prev_run;
    logic [15:0] max_freq_i, rated_volt_i, freq_ref_o, volt_ref_o;
    int failures = 0;
    int checked = 0;
    int n;

    // short tenth and hour factors keep the run brief
    step_sequencer_run_control #(.NUM_STEPS(16), .TENTH_CYCLES(4), .HOUR_FACTOR(3)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .run_cmd_i(run_cmd_i),
        .stop_cmd_i(stop_cmd_i), .power_fail_i(power_fail_i), .max_freq_i(max_freq_i),
        .rated_volt_i(rated_volt_i), .freq_ref_o(freq_ref_o), .volt_ref_o(volt_ref_o),
        .reverse_o(reverse_o), .running_o(running_o), .step_o(step_o));

    ////////////////////////////////////////////////////////////////////////////////
    // clock and verdict
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic results();
        if (failures == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // whole test needs well under a thousand cycles; a hang ends far later
    initial begin
        repeat (30000) @(posedge clk_i);
        failures++;
        results();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bus and command helpers; every change lands just after a rising edge
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        wb_adr_i <= a;
        wb_we_i <= w;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        @(posedge clk_i);
        // no local limit: only the watchdog ends a bus wait
        while (wb_ack_o !== 1'b1) begin
            @(posedge clk_i);
        end
        q = wb_dat_o;
        chk("bus_ack", {31'h0, wb_ack_o}, 32'h1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic pulse(input logic stop);
        if (stop) stop_cmd_i <= 1'b1;
        else run_cmd_i <= 1'b1;
        @(posedge clk_i);
        stop_cmd_i <= 1'b0;
        run_cmd_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask

    task automatic wait_step(input logic [3:0] s);
        int k;
        k = 0;
        while (step_o !== s && k < 1000) begin
            @(posedge clk_i);
            k++;
        end
        chk("step_wait", {28'h0, step_o}, {28'h0, s});
    endtask

    // counts the cycles spent on step 3, the long one
    task automatic measure();
        wait_step(4'h3);
        n = 0;
        while (step_o === 4'h3 && n < 1000) begin
            @(posedge clk_i);
            n++;
        end
    endtask

    task automatic outs(input logic [3:0] s, input logic [15:0] f, input logic r,
                        input logic run);
        chk("step", {28'h0, step_o}, {28'h0, s});
        chk("freq_ref", {16'h0, freq_ref_o}, {16'h0, f});
        chk("reverse", {31'h0, reverse_o}, {31'h0, r});
        chk("running", {31'h0, running_o}, {31'h0, run});
    endtask

    // steps must only move up by one while running, 15 wrapping to 0
    always @(posedge clk_i) begin
        if (!rst_i && prev_run && running_o && step_o !== prev_step) begin
            chk("step_order", {28'h0, step_o}, {28'h0, prev_step + 4'h1});
        end
        prev_step <= step_o;
        prev_run <= running_o;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // test sequence
    initial begin
        rst_i = 1'b1;
        {wb_we_i, wb_cyc_i, wb_stb_i, run_cmd_i, stop_cmd_i, power_fail_i} = 6'h00;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0;
        wb_sel_i = 4'h0;
        max_freq_i = 16'h1000;
        rated_volt_i = 16'h0800;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // reset values, unmapped place, mode write and read back
        wb(8'h00, 1'b0, 32'h0);
        chk("mode_rst", q, 32'h0);
        wb(8'h04, 1'b0, 32'h0);
        chk("retain_rst", q, 32'h0);
        wb(8'h08, 1'b0, 32'h0);
        chk("ctrl_rst", q, 32'h0);
        wb(8'hfc, 1'b1, 32'h0000_1234);
        wb(8'hfc, 1'b0, 32'h0);
        chk("unmapped", q, 32'h0);
        wb(8'h00, 1'b1, 32'h0000_0001);
        wb(8'h00, 1'b0, 32'h0);
        chk("mode_rw", q, 32'h1);
        // step 0 is -25.0 %, step 3 is 50.0 %, step 15 is 150.0 % (clamped), rest 12.5 %
        for (int i = 0; i < 16; i++) begin
            wb(8'h40 + 8'(4 * i), 1'b1,
               (i == 0) ? 32'h0000_ff06 : (i == 3) ? 32'd500 : (i == 15) ? 32'd1500 : 32'd125);
        end
        wb(8'h80, 1'b1, 32'd5);
        wb(8'h8c, 1'b1, 32'd10);
        // stop after one pass
        wb(8'h00, 1'b1, 32'h0);
        pulse(1'b0);
        outs(4'h0, 16'd1024, 1'b1, 1'b1);
        measure();
        chk("sec_len", {31'h0, n >= 38 && n <= 45}, 32'h1);
        wait_step(4'hf);
        repeat (4) @(posedge clk_i);
        outs(4'hf, 16'h0, 1'b0, 1'b0);
        wb(8'h0c, 1'b0, 32'h0);
        chk("state_done", {29'h0, q[6:4]}, 32'h3);
        repeat (40) @(posedge clk_i);
        chk("still_halted", {31'h0, running_o}, 32'h0);
        // hold the last step, restarting from step 0 out of the halted state
        wb(8'h00, 1'b1, 32'h1);
        pulse(1'b0);
        outs(4'h0, 16'd1024, 1'b1, 1'b1);
        wait_step(4'hf);
        repeat (40) @(posedge clk_i);
        outs(4'hf, 16'h1000, 1'b0, 1'b1);
        wb(8'h0c, 1'b0, 32'h0);
        chk("state_hold", {29'h0, q[6:4]}, 32'h2);
        pulse(1'b1);
        chk("hold_stop", {31'h0, running_o}, 32'h0);
        // repeat: wraps to step 0 and keeps going until stopped
        wb(8'h00, 1'b1, 32'h2);
        pulse(1'b0);
        wait_step(4'hf);
        wait_step(4'h0);
        chk("loop_run", {31'h0, running_o}, 32'h1);
        wait_step(4'h3);
        chk("loop_run2", {31'h0, running_o}, 32'h1);
        pulse(1'b1);
        chk("loop_stop", {31'h0, running_o}, 32'h0);
        // voltage target: frequency side stays quiet
        wb(8'h08, 1'b1, 32'h1);
        pulse(1'b0);
        chk("volt_ref", {16'h0, volt_ref_o}, 32'd512);
        outs(4'h0, 16'h0, 1'b0, 1'b1);
        pulse(1'b1);
        wb(8'h08, 1'b1, 32'h0);
        // retention on stop, then without it
        wb(8'h04, 1'b1, 32'd10);
        pulse(1'b0);
        wait_step(4'h3);
        pulse(1'b1);
        pulse(1'b0);
        outs(4'h3, 16'd2048, 1'b0, 1'b1);
        pulse(1'b1);
        wb(8'h04, 1'b1, 32'd0);
        pulse(1'b0);
        outs(4'h0, 16'd1024, 1'b1, 1'b1);
        // retention on power loss resumes without a run command
        wb(8'h04, 1'b1, 32'd1);
        wait_step(4'h3);
        power_fail_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        outs(4'h3, 16'h0, 1'b0, 1'b0);
        power_fail_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        outs(4'h3, 16'd2048, 1'b0, 1'b1);
        wb(8'h04, 1'b1, 32'd0);
        power_fail_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        power_fail_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        outs(4'h0, 16'h0, 1'b0, 1'b0);
        // hour unit stretches each tenth by the hour factor
        wb(8'h08, 1'b1, 32'h2);
        pulse(1'b0);
        measure();
        chk("hour_len", {31'h0, n >= 118 && n <= 125}, 32'h1);
        pulse(1'b1);
        results();
    end
endmodule
